//--- core/audio_port_defs.vh
`ifndef AUDIO_PORT_DEFS_VH
`define AUDIO_PORT_DEFS_VH

// Register word indices; byte address is four times the index
`define REG_A_CLOCK_CONTROL_IDX 6'h04
`define REG_B_CONTROL_ONE_IDX 6'h05
`define REG_CFG_STATUS_IDX 6'h06

// Reset values
`define A_CLOCK_CONTROL_RST 8'h00
`define B_CONTROL_ONE_RST 8'h00

// Port A clock control field positions
`define A_DIV_LSB 0
`define A_DIV_MSB 1
`define A_SRC_LSB 2
`define A_SRC_MSB 3

// Port B control field positions
`define B_FMT_LSB 0
`define B_FMT_MSB 2
`define B_ROLE_BIT 3
`define B_ROUTE_LSB 4
`define B_ROUTE_MSB 5
`define B_SILENCE_BIT 6

// Master clock source codes
`define SRC_MAIN 2'h0
`define SRC_RX_IN 2'h1
`define SRC_RX_RECOVERED 2'h2
`define SRC_RESERVED 2'h3

// Output route codes
`define ROUTE_LOOPBACK 2'h0
`define ROUTE_OTHER_PORT 2'h1
`define ROUTE_RECEIVER 2'h2
`define ROUTE_RESERVED 2'h3

// Data format codes
`define FMT_LJ24 3'h0
`define FMT_I2S24 3'h1
`define FMT_UNUSED2 3'h2
`define FMT_UNUSED3 3'h3
`define FMT_RJ16 3'h4
`define FMT_RJ18 3'h5
`define FMT_RJ20 3'h6
`define FMT_RJ24 3'h7

// Justification codes on the decoded output
`define JUST_LEFT 2'h0
`define JUST_I2S 2'h1
`define JUST_RIGHT 2'h2
`define JUST_NONE 2'h3

// Word lengths
`define WORD_16 5'h10
`define WORD_18 5'h12
`define WORD_20 5'h14
`define WORD_24 5'h18
`define WORD_NONE 5'h00

// Bit clock half periods per frame clock half period (64 bit clocks/frame)
`define HALVES_PER_FRAME_HALF 6'h3f

`endif

//--- core/frame_clock_divider.v
`timescale 1ns/1ps
`include "audio_port_defs.vh"

module frame_clock_divider (
  input wire clock_i,
  input wire rst_i,
  input wire run_i,
  input wire tick_i,
  input wire [1:0] div_sel_i,
  output wire bit_clock_o,
  output wire frame_clock_o
);

  reg [1:0] tick_cnt_ff;
  reg [5:0] half_cnt_ff;
  reg bit_ff;
  reg frame_ff;
  wire half_done;

  // Bit clock half period is div_sel+1 master edges: 128..512 per frame
  assign half_done = tick_i && (tick_cnt_ff == div_sel_i);

  // Idle divider parks both clocks low so a restart begins on a frame edge
  always @(posedge clock_i) begin
    if (rst_i || !run_i) begin
      tick_cnt_ff <= 2'h0;
      half_cnt_ff <= 6'h00;
      bit_ff <= 1'b0;
      frame_ff <= 1'b0;
    end else if (half_done) begin
      tick_cnt_ff <= 2'h0;
      bit_ff <= ~bit_ff;
      half_cnt_ff <= half_cnt_ff + 6'h01;
      // Frame toggles with the bit clock falling edge, 64 bits per frame
      if (half_cnt_ff == `HALVES_PER_FRAME_HALF) begin
        frame_ff <= ~frame_ff;
      end
    end else if (tick_i) begin
      tick_cnt_ff <= tick_cnt_ff + 2'h1;
    end
  end

  assign bit_clock_o = bit_ff;
  assign frame_clock_o = frame_ff;

endmodule

//--- core/audio_port_clock_format_cfg.v
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
`include "audio_port_defs.vh"

module audio_port_clock_format_cfg (
  input wire clock_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  // Master clock candidates, all pins
  input wire mclk_i,
  input wire receiver_clock_in_i,
  input wire recovered_receiver_clock_out_i,
  // Port A role from its other control register, same clock domain
  input wire a_master_mode_i,
  output wire a_frame_clock_o,
  output wire a_bit_clock_o,
  output wire a_clock_oe_o,
  // Port B clock pins, two-way
  input wire b_frame_clock_i,
  input wire b_bit_clock_i,
  output wire b_frame_clock_o,
  output wire b_bit_clock_o,
  output wire b_clock_oe_o,
  // Serial data sources for Port B output
  input wire b_serial_data_in_i,
  input wire a_serial_data_in_i,
  input wire receiver_data_i,
  output wire b_serial_data_out_o,
  // Decoded Port B format for the serializer
  output wire [4:0] b_word_bits_o,
  output wire [1:0] b_justify_o
);

  // Register storage
  reg [7:0] a_clock_control_ff;
  reg [7:0] b_control_one_ff;
  reg [31:0] rd_data_ff;
  reg ack_ff;

  // Pin synchronisers, stage one read only by stage two
  reg [2:0] src_meta_ff;
  reg [2:0] src_sync_ff;
  reg src_prev_ff;
  reg [1:0] bclk_meta_ff;
  reg [1:0] bclk_sync_ff;
  reg [2:0] data_meta_ff;
  reg [2:0] data_sync_ff;

  // Output flops
  reg a_frame_ff;
  reg a_bit_ff;
  reg a_oe_ff;
  reg b_frame_ff;
  reg b_bit_ff;
  reg b_oe_ff;
  reg b_sdo_ff;
  reg [4:0] word_bits_ff;
  reg [1:0] justify_ff;

  // Combinational next values
  reg src_sel_level;
  reg nxt_b_sdo;
  reg [6:0] nxt_format;
  reg [31:0] nxt_rd_data;

  wire [1:0] a_master_divider_sel;
  wire [1:0] a_src_sel;
  wire [2:0] b_data_format_sel;
  wire b_clock_role_sel;
  wire [1:0] b_output_route_sel;
  wire b_output_silence;
  wire master_tick;
  wire div_a_bit;
  wire div_a_frame;
  wire div_b_bit;
  wire div_b_frame;
  wire bus_req;
  wire [5:0] reg_idx;
  wire idx_hit;
  wire wr_a;
  wire wr_b;
  wire [7:0] status_byte;

  // Field views of the control registers
  assign a_master_divider_sel = a_clock_control_ff[`A_DIV_MSB:`A_DIV_LSB];
  assign a_src_sel = a_clock_control_ff[`A_SRC_MSB:`A_SRC_LSB];
  assign b_data_format_sel = b_control_one_ff[`B_FMT_MSB:`B_FMT_LSB];
  assign b_clock_role_sel = b_control_one_ff[`B_ROLE_BIT];
  assign b_output_route_sel = b_control_one_ff[`B_ROUTE_MSB:`B_ROUTE_LSB];
  assign b_output_silence = b_control_one_ff[`B_SILENCE_BIT];

  // Bus decode; low two address bits must be zero, word aligned
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign reg_idx = wb_adr_i[7:2];
  assign idx_hit = wb_adr_i[1:0] == 2'h0;
  assign wr_a = bus_req && wb_we_i && wb_sel_i[0] && idx_hit &&
                (reg_idx == `REG_A_CLOCK_CONTROL_IDX);
  assign wr_b = bus_req && wb_we_i && wb_sel_i[0] && idx_hit &&
                (reg_idx == `REG_B_CONTROL_ONE_IDX);

  // Control registers; only the low byte lane carries data
  always @(posedge clock_i) begin
    if (rst_i) begin
      a_clock_control_ff <= `A_CLOCK_CONTROL_RST;
      b_control_one_ff <= `B_CONTROL_ONE_RST;
    end else begin
      if (wr_a) begin
        // Upper nibble is not stored so it always reads zero
        a_clock_control_ff <= {4'h0, wb_dat_i[3:0]};
      end
      if (wr_b) begin
        // Bit 7 is forced zero, the rest kept as written
        b_control_one_ff <= {1'b0, wb_dat_i[6:0]};
      end
    end
  end

  // Status: live clock levels and flags for undefined codes
  assign status_byte = {3'h0,
                        (b_data_format_sel == `FMT_UNUSED2) ||
                        (b_data_format_sel == `FMT_UNUSED3),
                        b_output_route_sel == `ROUTE_RESERVED,
                        a_src_sel == `SRC_RESERVED,
                        b_frame_ff,
                        a_frame_ff};

  // Read mux; unmapped addresses answer zero
  always @* begin
    nxt_rd_data = 32'h00000000;
    if (idx_hit) begin
      case (reg_idx)
        `REG_A_CLOCK_CONTROL_IDX: begin
          nxt_rd_data = {24'h000000, a_clock_control_ff};
        end
        `REG_B_CONTROL_ONE_IDX: begin
          nxt_rd_data = {24'h000000, b_control_one_ff};
        end
        `REG_CFG_STATUS_IDX: begin
          nxt_rd_data = {24'h000000, status_byte};
        end
        default: begin
          nxt_rd_data = 32'h00000000;
        end
      endcase
    end
  end

  // Single cycle ack; dropped the cycle after so a held request is not
  // taken twice
  always @(posedge clock_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rd_data_ff <= 32'h00000000;
    end else begin
      ack_ff <= bus_req;
      if (bus_req) begin
        rd_data_ff <= nxt_rd_data;
      end
    end
  end

  // Two flops on every pin before anything looks at it
  always @(posedge clock_i) begin
    if (rst_i) begin
      src_meta_ff <= 3'h0;
      src_sync_ff <= 3'h0;
      bclk_meta_ff <= 2'h0;
      bclk_sync_ff <= 2'h0;
      data_meta_ff <= 3'h0;
      data_sync_ff <= 3'h0;
    end else begin
      src_meta_ff <= {recovered_receiver_clock_out_i,
                      receiver_clock_in_i, mclk_i};
      src_sync_ff <= src_meta_ff;
      bclk_meta_ff <= {b_frame_clock_i, b_bit_clock_i};
      bclk_sync_ff <= bclk_meta_ff;
      data_meta_ff <= {receiver_data_i, a_serial_data_in_i,
                       b_serial_data_in_i};
      data_sync_ff <= data_meta_ff;
    end
  end

  // Master source select; reserved code gives no edges at all
  always @* begin
    src_sel_level = 1'b0;
    case (a_src_sel)
      `SRC_MAIN: begin
        src_sel_level = src_sync_ff[0];
      end
      `SRC_RX_IN: begin
        src_sel_level = src_sync_ff[1];
      end
      `SRC_RX_RECOVERED: begin
        src_sel_level = src_sync_ff[2];
      end
      default: begin
        src_sel_level = 1'b0;
      end
    endcase
  end

  // Rising edge of the chosen master clock becomes an enable pulse.
  // Sampling limits the master clock to well under half of clock_i.
  always @(posedge clock_i) begin
    if (rst_i) begin
      src_prev_ff <= 1'b0;
    end else begin
      src_prev_ff <= src_sel_level;
    end
  end

  assign master_tick = src_sel_level && !src_prev_ff;

  // Port A divider runs only in master mode
  frame_clock_divider u_div_a (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .run_i(a_master_mode_i),
    .tick_i(master_tick),
    .div_sel_i(a_master_divider_sel),
    .bit_clock_o(div_a_bit),
    .frame_clock_o(div_a_frame)
  );

  // Port B master shares Port A source and divider setting
  frame_clock_divider u_div_b (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .run_i(b_clock_role_sel),
    .tick_i(master_tick),
    .div_sel_i(a_master_divider_sel),
    .bit_clock_o(div_b_bit),
    .frame_clock_o(div_b_frame)
  );

  // Clock outputs, re-registered so every port leaves a flop
  always @(posedge clock_i) begin
    if (rst_i) begin
      a_frame_ff <= 1'b0;
      a_bit_ff <= 1'b0;
      a_oe_ff <= 1'b0;
      b_frame_ff <= 1'b0;
      b_bit_ff <= 1'b0;
      b_oe_ff <= 1'b0;
    end else begin
      a_frame_ff <= div_a_frame;
      a_bit_ff <= div_a_bit;
      a_oe_ff <= a_master_mode_i;
      b_oe_ff <= b_clock_role_sel;
      if (b_clock_role_sel) begin
        b_frame_ff <= div_b_frame;
        b_bit_ff <= div_b_bit;
      end else begin
        // Slave: mirror the external clocks for status and the core
        b_frame_ff <= bclk_sync_ff[1];
        b_bit_ff <= bclk_sync_ff[0];
      end
    end
  end

  // Output route and mute; reserved route holds the line low
  always @* begin
    nxt_b_sdo = 1'b0;
    case (b_output_route_sel)
      `ROUTE_LOOPBACK: begin
        nxt_b_sdo = data_sync_ff[0];
      end
      `ROUTE_OTHER_PORT: begin
        nxt_b_sdo = data_sync_ff[1];
      end
      `ROUTE_RECEIVER: begin
        nxt_b_sdo = data_sync_ff[2];
      end
      default: begin
        nxt_b_sdo = 1'b0;
      end
    endcase
    if (b_output_silence) begin
      nxt_b_sdo = 1'b0;
    end
  end

  // Format decode as {justify, word}; unused codes report neither
  always @* begin
    nxt_format = {`JUST_NONE, `WORD_NONE};
    case (b_data_format_sel)
      `FMT_LJ24: nxt_format = {`JUST_LEFT, `WORD_24};
      `FMT_I2S24: nxt_format = {`JUST_I2S, `WORD_24};
      `FMT_RJ16: nxt_format = {`JUST_RIGHT, `WORD_16};
      `FMT_RJ18: nxt_format = {`JUST_RIGHT, `WORD_18};
      `FMT_RJ20: nxt_format = {`JUST_RIGHT, `WORD_20};
      `FMT_RJ24: nxt_format = {`JUST_RIGHT, `WORD_24};
      default: nxt_format = {`JUST_NONE, `WORD_NONE};
    endcase
  end

  // Data path and decoded format registers
  always @(posedge clock_i) begin
    if (rst_i) begin
      b_sdo_ff <= 1'b0;
      word_bits_ff <= `WORD_24;
      justify_ff <= `JUST_LEFT;
    end else begin
      b_sdo_ff <= nxt_b_sdo;
      word_bits_ff <= nxt_format[4:0];
      justify_ff <= nxt_format[6:5];
    end
  end

  assign wb_dat_o = rd_data_ff;
  assign wb_ack_o = ack_ff;
  assign a_frame_clock_o = a_frame_ff;
  assign a_bit_clock_o = a_bit_ff;
  assign a_clock_oe_o = a_oe_ff;
  assign b_frame_clock_o = b_frame_ff;
  assign b_bit_clock_o = b_bit_ff;
  assign b_clock_oe_o = b_oe_ff;
  assign b_serial_data_out_o = b_sdo_ff;
  assign b_word_bits_o = word_bits_ff;
  assign b_justify_o = justify_ff;

endmodule

//--- verification/audio_cfg_properties.sv
`timescale 1ns/1ps
module audio_cfg_checker (
  input wire clock_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  input wire a_master_mode_i,
  input wire a_frame_clock_o,
  input wire a_bit_clock_o,
  input wire a_clock_oe_o,
  input wire b_clock_oe_o,
  input wire b_frame_clock_i,
  input wire b_frame_clock_o,
  input wire b_serial_data_out_o,
  input wire [4:0] b_word_bits_o,
  input wire [1:0] b_justify_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Taken write to the port B control word
  wire wr_b = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o & wb_sel_i[0] &
    (wb_adr_i == 8'h14);
  a_ack_one_cycle: assert property (wb_cyc_i & wb_stb_i & !wb_ack_o
    |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one pulse");
  a_ack_has_request: assert property (wb_ack_o
    |-> $past(wb_cyc_i & wb_stb_i)) else $error("ack without request");
  a_oe_tracks_mode: assert property (1'b1
    |=> a_clock_oe_o == $past(a_master_mode_i)) else $error("a oe lag");
  a_frame_on_fall: assert property (a_master_mode_i &&
    $past(a_master_mode_i) && $changed(a_frame_clock_o)
    |-> $fell(a_bit_clock_o)) else $error("frame off bit fall");
  a_idle_clocks_low: assert property (!a_master_mode_i ##1
    !a_master_mode_i |=> !a_frame_clock_o && !a_bit_clock_o)
    else $error("a clocks run while idle");
  a_role_drives_pins: assert property (wr_b |-> ##2
    b_clock_oe_o == $past(wb_dat_i[3], 2)) else $error("b oe wrong");
  a_slave_mirror_frame: assert property (!b_clock_oe_o &&
    !$past(rst_i, 3) |-> b_frame_clock_o == $past(b_frame_clock_i, 3))
    else $error("b frame not mirrored");
  a_mute_forces_low: assert property (wr_b && wb_dat_i[6]
    |-> ##2 !b_serial_data_out_o) else $error("mute not low");
  a_reset_format: assert property ($past(rst_i) |->
    b_word_bits_o == 5'h18 && b_justify_o == 2'h0 && !wb_ack_o)
    else $error("reset format wrong");
  cover property (wr_b);
  cover property ($rose(a_frame_clock_o));
  cover property ($rose(b_clock_oe_o));
endmodule

bind audio_port_clock_format_cfg audio_cfg_checker u_audio_cfg_checker (
  .clock_i(clock_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .a_master_mode_i(a_master_mode_i), .a_frame_clock_o(a_frame_clock_o),
  .a_bit_clock_o(a_bit_clock_o), .a_clock_oe_o(a_clock_oe_o),
  .b_clock_oe_o(b_clock_oe_o), .b_frame_clock_i(b_frame_clock_i),
  .b_frame_clock_o(b_frame_clock_o),
  .b_serial_data_out_o(b_serial_data_out_o),
  .b_word_bits_o(b_word_bits_o), .b_justify_o(b_justify_o));

//--- verification/audio_source_model.sv
`timescale 1ns/1ps
// Far-side source: free master clocks, slave clocks and data
module audio_source_model (
  input wire clock_i,
  output reg mclk_o = 1'b0,
  output reg rx_clock_o = 1'b0,
  output reg rx_recovered_o = 1'b0,
  output wire b_frame_o,
  output wire b_bit_o,
  output wire [2:0] data_o
);
  reg [7:0] cnt_ff = 8'h00;
  // Periods of 8, 12 and 10 cycles, under a quarter of the system rate
  always #16 mclk_o = ~mclk_o;
  always #24 rx_clock_o = ~rx_clock_o;
  always #20 rx_recovered_o = ~rx_recovered_o;
  // Slave clocks: 64 bit toggles per frame half
  always @(posedge clock_i) begin
    cnt_ff <= cnt_ff + 8'h01;
  end
  assign b_bit_o = cnt_ff[1];
  assign b_frame_o = cnt_ff[7];
  assign data_o = cnt_ff[3:1];
endmodule

//--- verification/audio_port_clock_format_cfg_test.sv
`timescale 1ns/1ps
`define CHECK(n, e, g) check_val(n, (e) === (g), e, g)
module audio_port_clock_format_cfg_test;
  // Expected {justify, word} per format code, code 7 first
  localparam [55:0] FMT_TAB = {7'h58, 7'h54, 7'h52, 7'h50, 7'h60, 7'h60,
    7'h38, 7'h18};
  reg clock_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, mode = 1'b0;
  reg pick = 1'b0, fr, bt;
  reg [7:0] adr = 8'h00;
  reg [31:0] wdat = 32'h0, rd;
  reg [2:0] d1, d2, d3;
  integer err_total = 0, n_compared = 0, i, k, t, n;
  wire [31:0] rdat;
  wire [4:0] wbits;
  wire [1:0] just;
  wire [2:0] dat;
  wire ack, mclk, rxc, rxr, mf, mb, afc, abc, aoe, bfo, bbo, boe, sdo;
  // Two-way B clock pins resolved from the enable
  wire bfi = boe ? bfo : mf;
  wire bbi = boe ? bbo : mb;
  wire sf = pick ? bfo : afc;
  wire sb = pick ? bbo : abc;

  always #2 clock_i = ~clock_i;
  // Reference delay line: two sync stages plus the output stage
  always @(posedge clock_i) begin
    d1 <= dat;
    d2 <= d1;
    d3 <= d2;
  end

  audio_source_model u_audio_source_model (
    .clock_i(clock_i), .mclk_o(mclk), .rx_clock_o(rxc),
    .rx_recovered_o(rxr), .b_frame_o(mf), .b_bit_o(mb), .data_o(dat));

  audio_port_clock_format_cfg u_audio_port_clock_format_cfg (
    .clock_i(clock_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .mclk_i(mclk),
    .receiver_clock_in_i(rxc), .recovered_receiver_clock_out_i(rxr),
    .a_master_mode_i(mode), .a_frame_clock_o(afc), .a_bit_clock_o(abc),
    .a_clock_oe_o(aoe), .b_frame_clock_i(bfi), .b_bit_clock_i(bbi),
    .b_frame_clock_o(bfo), .b_bit_clock_o(bbo), .b_clock_oe_o(boe),
    .b_serial_data_in_i(dat[0]), .a_serial_data_in_i(dat[1]),
    .receiver_data_i(dat[2]), .b_serial_data_out_o(sdo),
    .b_word_bits_o(wbits), .b_justify_o(just));

  task summarize;
    begin
      if (err_total == 0 && n_compared > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask

  // Count every compare, report a mismatch at once
  task check_val(input [79:0] name, input ok, input [31:0] e,
    input [31:0] g);
    begin
      n_compared = n_compared + 1;
      if (!ok) begin
        err_total = err_total + 1;
        $display("Error %0s expected %h seen %h", name, e, g);
      end
    end
  endtask

  // Classic single cycle; the answer wait is bounded
  task xfer(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clock_i);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      t = 0;
      @(posedge clock_i);
      while (ack !== 1'b1 && t < 20) begin
        @(posedge clock_i);
        t = t + 1;
      end
      rd = rdat;
      cyc <= 1'b0;
      if (t == 20) begin
        err_total = err_total + 1;
        summarize;
      end
    end
  endtask

  // Skip to a frame edge, then time one whole frame half
  task measure(input [11:0] half);
    begin
      for (k = 0; k < 2; k = k + 1) begin
        fr = sf;
        t = 0;
        n = 0;
        while (sf === fr && t < 5000) begin
          bt = sb;
          @(posedge clock_i);
          t = t + 1;
          n = n + (bt === 1'b0 && sb === 1'b1);
        end
        if (t == 5000) begin
          err_total = err_total + 1;
          summarize;
        end
      end
      `CHECK("half", half, t);
      `CHECK("rises", 32, n);
    end
  endtask

  initial begin
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    `CHECK("format", 7'h18, {just, wbits});
    xfer(0, 8'h10, 0);
    `CHECK("a_reg", 32'h0, rd);
    xfer(1, 8'h10, 32'hff);
    xfer(0, 8'h10, 0);
    `CHECK("a_reg", 32'h0f, rd);
    xfer(0, 8'h14, 0);
    `CHECK("b_reg", 32'h0, rd);
    xfer(1, 8'h14, 32'hff);
    xfer(0, 8'h14, 0);
    `CHECK("b_reg", 32'h7f, rd);
    xfer(0, 8'h18, 0);
    `CHECK("status", 32'h0c, rd);
    xfer(0, 8'h20, 0);
    `CHECK("unmapped", 32'h0, rd);
    for (i = 0; i < 8; i = i + 1) begin
      xfer(1, 8'h14, i);
      repeat (2) @(posedge clock_i);
      `CHECK("format", FMT_TAB[i*7 +: 7], {just, wbits});
    end
    // Routes 0..3, then mute over the loopback route
    for (i = 0; i < 5; i = i + 1) begin
      xfer(1, 8'h14, (i < 4) ? i << 4 : 32'h40);
      repeat (4) @(posedge clock_i);
      for (k = 0; k < 16; k = k + 1) begin
        @(posedge clock_i);
        `CHECK("data_out", (i < 3) ? d3[i] : 1'b0, sdo);
      end
    end
    mode <= 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      xfer(1, 8'h10, i);
      measure((i + 1) * 512);
    end
    xfer(1, 8'h10, 32'h04);
    measure(768);
    xfer(1, 8'h10, 32'h08);
    measure(640);
    xfer(1, 8'h10, 32'h00);
    xfer(1, 8'h14, 32'h08);
    @(posedge clock_i);
    `CHECK("b_oe", 1'b1, boe);
    pick = 1'b1;
    measure(512);
    mode <= 1'b0;
    xfer(1, 8'h14, 32'h00);
    repeat (3) @(posedge clock_i);
    `CHECK("idle", 4'h0, {aoe, boe, afc, abc});
    summarize;
  end
endmodule
